// File: global_pins_defs.vh
`ifndef GLOBAL_PINS_DEFS_VH
`define GLOBAL_PINS_DEFS_VH

// register byte offsets
`define REG_PIN_CTRL 8'h00
`define REG_INPUT_B_CONFIG 8'h04
`define REG_INPUT_C_CONFIG 8'h08
`define REG_OUT_INPUT_RATE_FIELD 8'h0c
`define REG_RATE_SELECT 8'h10
`define REG_GP_PIN_CONTROL 8'h14
`define REG_GP_PIN_STATE 8'h18
`define REG_STATUS 8'h1c

// pin control fields
`define CTRL_REF_FAIL_PIN_EN 0
`define CTRL_LOCK_IND_EN 1
`define CTRL_ABSENCE_MODE 2
`define CTRL_IRQ_ACTIVE_LOW 3
`define CTRL_IRQ_OPEN_DRAIN 4
`define CTRL_IRQ_GP_MODE 5
`define CTRL_IRQ_GP_VALUE 6
`define CTRL_WIDTH 7
`define CTRL_RESET 7'h00

// output frequency fields
`define OUT_CMOS_LSB 0
`define OUT_DIFF_LSB 4

// rate select fields
`define RATE_FAMILY_BIT 0
`define RATE_SYNTH1_BIT 1
`define RATE_SYNTH2_BIT 2

// gp control fields
`define GP_DIR_LSB 0
`define GP_OUT_LSB 4

// status fields
`define STAT_SEL_B 0
`define STAT_REF_FAIL 1
`define STAT_LOCKED 2
`define STAT_CAPTURED 3
`define STAT_IRQ_PIN 4

// reset values of strap-loaded fields and gp control bits before capture
`define RATE_FIELD_RESET 4'h0
`define FREQ3_RESET 3'h0
`define GP_CONTROL_RESET 1'b0

// cycles from pin reset release to strap capture
`define RELEASE_STAGES 4

`endif

// File: sync3.v
// pin synchroniser: three flops, change taken once stages two and three agree
module sync3 #(
   parameter WIDTH = 1
) (
   // clock
   input wire clk,
   // asynchronous level in, settled level out
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] level
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   integer i;

   // shift chain; only stage2 reads stage1
   always @(posedge clk)
   begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1)
      begin
         if (stage2[i] == stage3[i])
            level[i] <= stage3[i];
      end
   end
endmodule // sync3

// File: gp_pin_cell.v
// one shared strap / general-purpose pin
module gp_pin_cell (
   // clock
   input wire clk,
   // function select
   input wire released,
   input wire direction,
   input wire out_value,
   // pad signals
   input wire pin_in,
   output wire pin_out,
   output wire pin_oe,
   // settled pin level
   output wire level
);
   // strap phase keeps the pin an input; afterwards direction bit rules
   assign pin_oe = released & direction;
   assign pin_out = out_value;

   // live level for the state register
   sync3 #(
      .WIDTH(1)
   ) u_sync (
      .clk(clk),
      .async_in(pin_in),
      .level(level)
   );
endmodule // gp_pin_cell

// File: global_strap_pins.v
`include "global_pins_defs.vh"

// Behaviour
// - reset pin low clears all state except PRDATA and the synchronisers immediately
// - stay reset while pin low, run after
// - switch high picks input B, low C
// - input rate straps load both config fields
// - cmos output rate straps set default
// - diff output straps set default, then GPIO
// - fail pin mirrors failure, else high-Z
// - lock pin shows lock, else drives low
// - gp pins follow direction and value bits
// - rate strap sets family and synth defaults
// - mode bit picks interrupt or loss output
// - irq polarity, drive type, general output
// - loss mode shows live activity, unlatched
// - open input straps give 8 kHz code
// - open diff straps give 38.88 MHz code
module global_strap_pins #(
   parameter GP_COUNT = 4
) (
   // clock and resets
   input wire CLK,
   input wire RST,
   input wire MASTER_RESET_N,
   // apb slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   // source switch pin
   input wire SOURCE_SWITCH_IN,
   // input frequency strap pins
   input wire [2:0] IN_INPUT_RATE_FIELD_STRAP,
   // cmos output strap 0, input only
   input wire CMOS_OUT_STRAP_BIT0,
   // cmos strap 1 / selected reference failure pin
   input wire REF_FAIL_PIN_IN,
   output wire REF_FAIL_PIN_OUT,
   output wire REF_FAIL_PIN_OE,
   // cmos strap 2 / lock pin
   input wire LOCK_PIN_IN,
   output wire LOCK_PIN_OUT,
   output wire LOCK_PIN_OE,
   // diff straps 0..2 and rate strap, then general-purpose pins 1..4
   input wire [GP_COUNT-1:0] GP_PIN_IN,
   output wire [GP_COUNT-1:0] GP_PIN_OUT,
   output wire [GP_COUNT-1:0] GP_PIN_OE,
   // interrupt / loss pin
   output wire IRQ_PIN_OUT,
   output wire IRQ_PIN_OE,
   // status from the clock monitors and dpll
   input wire SELECTED_REF_FAILURE,
   input wire MAIN_DPLL_LOCKED,
   input wire ACTIVITY_B,
   input wire ACTIVITY_C,
   input wire IRQ_REQUEST,
   // configuration to the rest of the device
   output wire REF_SELECT_B,
   output wire DEVICE_RUN,
   output reg [3:0] INPUT_B_RATE,
   output reg [3:0] INPUT_C_RATE,
   output reg [2:0] CMOS_OUT_INPUT_RATE_FIELD,
   output reg [2:0] DIFF_OUT_INPUT_RATE_FIELD,
   output reg RATE_FAMILY,
   output reg SYNTH1_STD,
   output reg SYNTH2_STD
);
   reg [`RELEASE_STAGES-1:0] release_chain;
   reg captured;
   reg [`CTRL_WIDTH-1:0] pin_ctrl;
   reg [GP_COUNT-1:0] gp_dir;
   reg [GP_COUNT-1:0] gp_out;
   reg ref_select_b;
   reg [31:0] next_rdata;
   reg addr_ok;
   wire released;
   wire capture;
   wire [2:0] in_input_rate_field_level;
   wire [2:0] cmos_level;
   wire switch_level;
   wire [GP_COUNT-1:0] gp_level;
   wire access;
   wire wr;
   wire irq_active;
   wire irq_value;
   wire loss_of_ref;

   // release chain: cleared at once by the pin, released on clock
   always @(posedge CLK or negedge MASTER_RESET_N)
   begin
      if (!MASTER_RESET_N)
         release_chain <= {`RELEASE_STAGES{1'b0}};
      else if (RST)
         release_chain <= {`RELEASE_STAGES{1'b0}};
      else
         release_chain <= {release_chain[`RELEASE_STAGES-2:0], 1'b1};
   end

   // last stage gives time for strap synchronisers to settle
   assign released = release_chain[`RELEASE_STAGES-1];
   assign DEVICE_RUN = captured;

   // strap and switch pin synchronisers
   sync3 #(
      .WIDTH(3)
   ) u_in_input_rate_field_sync (
      .clk(CLK),
      .async_in(IN_INPUT_RATE_FIELD_STRAP),
      .level(in_input_rate_field_level)
   );

   sync3 #(
      .WIDTH(3)
   ) u_cmos_sync (
      .clk(CLK),
      .async_in({LOCK_PIN_IN, REF_FAIL_PIN_IN, CMOS_OUT_STRAP_BIT0}),
      .level(cmos_level)
   );

   sync3 #(
      .WIDTH(1)
   ) u_switch_sync (
      .clk(CLK),
      .async_in(SOURCE_SWITCH_IN),
      .level(switch_level)
   );

   // general-purpose pin cells, straps while not released
   genvar g;
   generate
      for (g = 0; g < GP_COUNT; g = g + 1)
      begin : gp
         gp_pin_cell u_cell (
            .clk(CLK),
            .released(captured),
            .direction(gp_dir[g]),
            .out_value(gp_out[g]),
            .pin_in(GP_PIN_IN[g]),
            .pin_out(GP_PIN_OUT[g]),
            .pin_oe(GP_PIN_OE[g]),
            .level(gp_level[g])
         );
      end
   endgenerate

   // one-shot capture pulse at first released cycle
   assign capture = released & ~captured;

   always @(posedge CLK or negedge MASTER_RESET_N)
   begin
      if (!MASTER_RESET_N)
         captured <= 1'b0;
      else if (RST)
         captured <= 1'b0;
      else if (capture)
         captured <= 1'b1;
   end

   // source selection follows the settled switch level once out of reset
   always @(posedge CLK or negedge MASTER_RESET_N)
   begin
      if (!MASTER_RESET_N)
         ref_select_b <= 1'b0;
      else if (RST)
         ref_select_b <= 1'b0;
      else if (released)
         ref_select_b <= switch_level;
   end

   assign REF_SELECT_B = ref_select_b;

   // apb handshake: zero wait states, error on unmapped offset
   assign access = PSEL & PENABLE;
   assign PREADY = 1'b1;
   assign PSLVERR = access & ~addr_ok;
   assign wr = access & PWRITE & addr_ok & captured;

   // address decode and read mux
   always @*
   begin
      next_rdata = 32'h0000_0000;
      addr_ok = 1'b1;
      case (PADDR)
         `REG_PIN_CTRL:
            next_rdata[`CTRL_WIDTH-1:0] = pin_ctrl;
         `REG_INPUT_B_CONFIG:
            next_rdata[3:0] = INPUT_B_RATE;
         `REG_INPUT_C_CONFIG:
            next_rdata[3:0] = INPUT_C_RATE;
         `REG_OUT_INPUT_RATE_FIELD:
         begin
            next_rdata[`OUT_CMOS_LSB+2:`OUT_CMOS_LSB] = CMOS_OUT_INPUT_RATE_FIELD;
            next_rdata[`OUT_DIFF_LSB+2:`OUT_DIFF_LSB] = DIFF_OUT_INPUT_RATE_FIELD;
         end
         `REG_RATE_SELECT:
         begin
            next_rdata[`RATE_FAMILY_BIT] = RATE_FAMILY;
            next_rdata[`RATE_SYNTH1_BIT] = SYNTH1_STD;
            next_rdata[`RATE_SYNTH2_BIT] = SYNTH2_STD;
         end
         `REG_GP_PIN_CONTROL:
         begin
            next_rdata[`GP_DIR_LSB+GP_COUNT-1:`GP_DIR_LSB] = gp_dir;
            next_rdata[`GP_OUT_LSB+GP_COUNT-1:`GP_OUT_LSB] = gp_out;
         end
         `REG_GP_PIN_STATE:
            next_rdata[GP_COUNT-1:0] = gp_level;
         `REG_STATUS:
         begin
            next_rdata[`STAT_SEL_B] = ref_select_b;
            next_rdata[`STAT_REF_FAIL] = SELECTED_REF_FAILURE;
            next_rdata[`STAT_LOCKED] = MAIN_DPLL_LOCKED;
            next_rdata[`STAT_CAPTURED] = captured;
            next_rdata[`STAT_IRQ_PIN] = irq_value;
         end
         default:
            addr_ok = 1'b0;
      endcase
   end

   // read data latched in the setup phase, valid in access
   always @(posedge CLK)
   begin
      if (RST)
         PRDATA <= 32'h0000_0000;
      else if (PSEL & ~PENABLE)
         PRDATA <= next_rdata;
   end

   // pin control and gp control registers
   always @(posedge CLK or negedge MASTER_RESET_N)
   begin
      if (!MASTER_RESET_N)
      begin
         pin_ctrl <= `CTRL_RESET;
         gp_dir <= {GP_COUNT{`GP_CONTROL_RESET}};
         gp_out <= {GP_COUNT{`GP_CONTROL_RESET}};
      end
      else if (RST)
      begin
         pin_ctrl <= `CTRL_RESET;
         gp_dir <= {GP_COUNT{`GP_CONTROL_RESET}};
         gp_out <= {GP_COUNT{`GP_CONTROL_RESET}};
      end
      else if (wr & (PADDR == `REG_PIN_CTRL))
         pin_ctrl <= PWDATA[`CTRL_WIDTH-1:0];
      else if (wr & (PADDR == `REG_GP_PIN_CONTROL))
      begin
         gp_dir <= PWDATA[`GP_DIR_LSB+GP_COUNT-1:`GP_DIR_LSB];
         gp_out <= PWDATA[`GP_OUT_LSB+GP_COUNT-1:`GP_OUT_LSB];
      end
   end

   // strap-loaded defaults, writable once running
   always @(posedge CLK or negedge MASTER_RESET_N)
   begin
      if (!MASTER_RESET_N)
      begin
         INPUT_B_RATE <= `RATE_FIELD_RESET;
         INPUT_C_RATE <= `RATE_FIELD_RESET;
         CMOS_OUT_INPUT_RATE_FIELD <= `FREQ3_RESET;
         DIFF_OUT_INPUT_RATE_FIELD <= `FREQ3_RESET;
         RATE_FAMILY <= 1'b0;
         SYNTH1_STD <= 1'b0;
         SYNTH2_STD <= 1'b0;
      end
      else if (RST)
      begin
         INPUT_B_RATE <= `RATE_FIELD_RESET;
         INPUT_C_RATE <= `RATE_FIELD_RESET;
         CMOS_OUT_INPUT_RATE_FIELD <= `FREQ3_RESET;
         DIFF_OUT_INPUT_RATE_FIELD <= `FREQ3_RESET;
         RATE_FAMILY <= 1'b0;
         SYNTH1_STD <= 1'b0;
         SYNTH2_STD <= 1'b0;
      end
      else if (capture)
      begin
         // open input straps read 000, the 8 kHz code
         INPUT_B_RATE <= {1'b0, in_input_rate_field_level};
         INPUT_C_RATE <= {1'b0, in_input_rate_field_level};
         CMOS_OUT_INPUT_RATE_FIELD <= cmos_level;
         // open diff straps read 100, the 38.88 MHz code
         DIFF_OUT_INPUT_RATE_FIELD <= gp_level[2:0];
         RATE_FAMILY <= gp_level[3];
         SYNTH1_STD <= gp_level[3];
         SYNTH2_STD <= gp_level[3];
      end
      else if (wr)
      begin
         case (PADDR)
            `REG_INPUT_B_CONFIG:
               INPUT_B_RATE <= PWDATA[3:0];
            `REG_INPUT_C_CONFIG:
               INPUT_C_RATE <= PWDATA[3:0];
            `REG_OUT_INPUT_RATE_FIELD:
            begin
               CMOS_OUT_INPUT_RATE_FIELD <= PWDATA[`OUT_CMOS_LSB+2:`OUT_CMOS_LSB];
               DIFF_OUT_INPUT_RATE_FIELD <= PWDATA[`OUT_DIFF_LSB+2:`OUT_DIFF_LSB];
            end
            `REG_RATE_SELECT:
            begin
               RATE_FAMILY <= PWDATA[`RATE_FAMILY_BIT];
               SYNTH1_STD <= PWDATA[`RATE_SYNTH1_BIT];
               SYNTH2_STD <= PWDATA[`RATE_SYNTH2_BIT];
            end
            default:
               RATE_FAMILY <= RATE_FAMILY;
         endcase
      end
   end

   // failure pin: mirror when enabled, released only after capture
   assign REF_FAIL_PIN_OUT = SELECTED_REF_FAILURE;
   assign REF_FAIL_PIN_OE = captured & pin_ctrl[`CTRL_REF_FAIL_PIN_EN];

   // lock pin: lock state when enabled, driven low otherwise
   assign LOCK_PIN_OUT = pin_ctrl[`CTRL_LOCK_IND_EN] & MAIN_DPLL_LOCKED;
   assign LOCK_PIN_OE = captured;

   // loss of the selected reference, straight from the live monitor
   assign loss_of_ref = ref_select_b ? ~ACTIVITY_B : ~ACTIVITY_C;

   // interrupt source or plain output level, before polarity
   assign irq_active = pin_ctrl[`CTRL_IRQ_GP_MODE] ? pin_ctrl[`CTRL_IRQ_GP_VALUE] : IRQ_REQUEST;

   // pin value: loss level in absence mode, else polarised request
   assign irq_value = pin_ctrl[`CTRL_ABSENCE_MODE] ? loss_of_ref
      : (irq_active ^ pin_ctrl[`CTRL_IRQ_ACTIVE_LOW]);

   // open drain only pulls low; push-pull drives both levels
   assign IRQ_PIN_OUT = (pin_ctrl[`CTRL_IRQ_OPEN_DRAIN] & ~pin_ctrl[`CTRL_ABSENCE_MODE]) ? 1'b0 : irq_value;
   assign IRQ_PIN_OE = captured & ((pin_ctrl[`CTRL_IRQ_OPEN_DRAIN] & ~pin_ctrl[`CTRL_ABSENCE_MODE])
      ? ~irq_value : 1'b1);
endmodule // global_strap_pins

// File: strap_board.sv
// board straps, host drivers and pad resolution
module strap_board (
   // device drive of each pad
   input wire [9:0] dev_out,
   input wire [9:0] dev_oe,
   input wire irq_out,
   input wire irq_oe,
   // board straps and host drivers
   input wire [9:0] brd_en,
   input wire [9:0] brd_val,
   // resolved pad levels
   output wire [9:0] level,
   output wire irq_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // internal pulls: open straps read as the 8 kHz and 38.88 MHz codes
   localparam logic [9:0] PULL = 10'h118;
   // device wins, then board, then pull
   assign level = (dev_oe & dev_out) | (~dev_oe & brd_en & brd_val) | (~dev_oe & ~brd_en & PULL);
   // board pull-up for open-drain use
   assign irq_level = irq_oe ? irq_out : 1'b1;
endmodule // strap_board

// File: global_strap_pins_chk.sv
`include "global_pins_defs.vh"
module strap_chk #(
   parameter GP_COUNT = 4
) (
   // clock and resets
   input wire CLK,
   input wire RST,
   input wire MASTER_RESET_N,
   // apb request
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   // pins
   input wire SOURCE_SWITCH_IN,
   input wire REF_FAIL_PIN_OUT,
   input wire REF_FAIL_PIN_OE,
   input wire LOCK_PIN_OUT,
   input wire LOCK_PIN_OE,
   input wire [GP_COUNT-1:0] GP_PIN_OUT,
   input wire [GP_COUNT-1:0] GP_PIN_OE,
   input wire IRQ_PIN_OUT,
   input wire IRQ_PIN_OE,
   // status in
   input wire SELECTED_REF_FAILURE,
   input wire MAIN_DPLL_LOCKED,
   input wire ACTIVITY_B,
   input wire ACTIVITY_C,
   input wire IRQ_REQUEST,
   // configuration out
   input wire REF_SELECT_B,
   input wire DEVICE_RUN,
   input wire [3:0] INPUT_B_RATE,
   input wire [2:0] CMOS_OUT_INPUT_RATE_FIELD,
   input wire [2:0] DIFF_OUT_INPUT_RATE_FIELD,
   input wire RATE_FAMILY
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [6:0] ctrl;
   reg [7:0] gpc;
   wire wr = PSEL && PENABLE && PWRITE && DEVICE_RUN;
   wire irq_v = (ctrl[5] ? ctrl[6] : IRQ_REQUEST) ^ ctrl[3];
   // mirror of pin and gp control, writes only once running
   always @(posedge CLK or negedge MASTER_RESET_N)
   begin
      if (!MASTER_RESET_N || RST)
      begin
         ctrl <= 7'h00;
         gpc <= 8'h00;
      end
      else if (wr && PADDR == `REG_PIN_CTRL)
         ctrl <= PWDATA[6:0];
      else if (wr && PADDR == `REG_GP_PIN_CONTROL)
         gpc <= PWDATA[7:0];
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   a_reset_clears: assert property (!MASTER_RESET_N |-> !DEVICE_RUN && !REF_FAIL_PIN_OE &&
      !LOCK_PIN_OE && GP_PIN_OE == 0 && !IRQ_PIN_OE) else $error("pin driven in reset");
   a_run_delay: assert property ($rose(DEVICE_RUN) |-> $past(MASTER_RESET_N, 4) && !$past(RST, 4))
      else $error("run too early");
   a_straps_hold: assert property (DEVICE_RUN && $past(DEVICE_RUN) && !$past(RST) && !$past(wr) |->
      $stable({INPUT_B_RATE, CMOS_OUT_INPUT_RATE_FIELD, DIFF_OUT_INPUT_RATE_FIELD, RATE_FAMILY})) else $error("strap field moved");
   a_fail_pin: assert property (DEVICE_RUN |-> REF_FAIL_PIN_OE == ctrl[0] &&
      REF_FAIL_PIN_OUT == SELECTED_REF_FAILURE) else $error("fail pin wrong");
   a_lock_pin: assert property (DEVICE_RUN |-> LOCK_PIN_OE &&
      LOCK_PIN_OUT == (ctrl[1] && MAIN_DPLL_LOCKED)) else $error("lock pin wrong");
   a_loss_mode: assert property (DEVICE_RUN && ctrl[2] |-> IRQ_PIN_OE &&
      IRQ_PIN_OUT == !(REF_SELECT_B ? ACTIVITY_B : ACTIVITY_C)) else $error("loss pin wrong");
   a_irq_mode: assert property (DEVICE_RUN && !ctrl[2] |-> (ctrl[4] ? !IRQ_PIN_OUT && IRQ_PIN_OE == !irq_v
      : IRQ_PIN_OE && IRQ_PIN_OUT == irq_v)) else $error("irq pin wrong");
   a_gp_pins: assert property (DEVICE_RUN |-> GP_PIN_OE == gpc[GP_COUNT-1:0] &&
      GP_PIN_OUT == gpc[GP_COUNT+3:4]) else $error("gp pin wrong");
   a_select_sync: assert property (MASTER_RESET_N && $past(MASTER_RESET_N) && !$past(RST) &&
      $changed(REF_SELECT_B) |-> $past(SOURCE_SWITCH_IN, 2) == REF_SELECT_B &&
      $past(SOURCE_SWITCH_IN, 3) == REF_SELECT_B) else $error("select not synchronised");
   c_run: cover property ($rose(DEVICE_RUN));
   c_loss: cover property (DEVICE_RUN && ctrl[2] && IRQ_PIN_OUT);
   c_drain: cover property (DEVICE_RUN && ctrl[4] && !IRQ_PIN_OE);
   c_switch: cover property ($changed(REF_SELECT_B));
endmodule // strap_chk

// File: tb_top.sv
`include "global_pins_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int GP_COUNT = 4;
   localparam int LIMIT = 4000;
   logic clk, rst, rstn, psel, penable, pwrite, sw, fail, locked, act_b, act_c, irq_req, err;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [9:0] brd_en, brd_val;
   wire [31:0] prdata;
   wire pready, pslverr, ref_out, ref_oe, lock_out, lock_oe, irq_out, irq_oe, sel_b, run, irq_lvl;
   wire [3:0] gp_out, gp_oe, b_rate, c_rate;
   wire [2:0] cmos_f, diff_f;
   wire fam, s1, s2;
   wire [9:0] lvl;
   int bad_count, n_compared, cycles;
   global_strap_pins #(.GP_COUNT(GP_COUNT)) i_dut (.CLK(clk), .RST(rst), .MASTER_RESET_N(rstn),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .SOURCE_SWITCH_IN(sw), .IN_INPUT_RATE_FIELD_STRAP(lvl[2:0]),
      .CMOS_OUT_STRAP_BIT0(lvl[3]), .REF_FAIL_PIN_IN(lvl[4]), .REF_FAIL_PIN_OUT(ref_out),
      .REF_FAIL_PIN_OE(ref_oe), .LOCK_PIN_IN(lvl[5]), .LOCK_PIN_OUT(lock_out), .LOCK_PIN_OE(lock_oe),
      .GP_PIN_IN(lvl[9:6]), .GP_PIN_OUT(gp_out), .GP_PIN_OE(gp_oe), .IRQ_PIN_OUT(irq_out),
      .IRQ_PIN_OE(irq_oe), .SELECTED_REF_FAILURE(fail), .MAIN_DPLL_LOCKED(locked), .ACTIVITY_B(act_b),
      .ACTIVITY_C(act_c), .IRQ_REQUEST(irq_req), .REF_SELECT_B(sel_b), .DEVICE_RUN(run),
      .INPUT_B_RATE(b_rate), .INPUT_C_RATE(c_rate), .CMOS_OUT_INPUT_RATE_FIELD(cmos_f), .DIFF_OUT_INPUT_RATE_FIELD(diff_f),
      .RATE_FAMILY(fam), .SYNTH1_STD(s1), .SYNTH2_STD(s2));
   strap_board i_board (.dev_out({gp_out, lock_out, ref_out, 4'h0}), .dev_oe({gp_oe, lock_oe, ref_oe, 4'h0}),
      .irq_out(irq_out), .irq_oe(irq_oe), .brd_en(brd_en), .brd_val(brd_val), .level(lvl), .irq_level(irq_lvl));
   // clock, 40 ns
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer plus an idle cycle
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         bad_count++;
         finish_test;
      end
   end
   // main sequence
   initial
   begin
      int n;
      logic [31:0] c;
      logic v;
      {rst, rstn, psel, penable, pwrite, sw, fail, locked, act_b, act_c, irq_req} = 11'h400;
      paddr = 8'h00;
      pwdata = 32'h0;
      brd_en = 10'h000;
      brd_val = 10'h000;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // open straps, then fitted straps with a mid-run reset
      for (int i = 0; i < 2; i++)
      begin
         brd_en <= i ? 10'h3ff : 10'h000;
         brd_val <= 10'h2e5;
         rstn <= 1'b0;
         @(negedge clk);
         chk({31'h0, run}, 32'h0);
         @(posedge clk);
         wr(`REG_PIN_CTRL, 32'h7f);
         repeat (3) @(posedge clk);
         rstn <= 1'b1;
         n = 0;
         while (run !== 1'b1 && n < 20)
         begin
            @(posedge clk);
            n++;
         end
         chk({31'h0, run}, 32'h1);
         brd_val <= ~10'h2e5;
         repeat (8) @(posedge clk);
         rd(`REG_PIN_CTRL, 32'h0);
         rd(`REG_INPUT_B_CONFIG, i ? 32'h5 : 32'h0);
         rd(`REG_INPUT_C_CONFIG, i ? 32'h5 : 32'h0);
         rd(`REG_OUT_INPUT_RATE_FIELD, i ? 32'h34 : 32'h43);
         rd(`REG_RATE_SELECT, i ? 32'h7 : 32'h0);
         $display("strap test %0d done", i);
      end
      rd(8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      // failure and lock pins
      brd_en <= 10'h000;
      for (int i = 0; i < 3; i++)
      begin
         c = (i < 2) ? 32'h3 : 32'h0;
         wr(`REG_PIN_CTRL, c);
         fail <= (i != 1);
         locked <= (i != 1);
         @(negedge clk);
         chk({28'h0, lvl[5:4], ref_oe, lock_oe}, {28'h0, c[1] && i != 1, c[0] ? i != 1 : 1'b1, c[0], 1'b1});
         @(posedge clk);
      end
      // interrupt modes: polarity, drive, general output
      for (int i = 0; i < 12; i++)
      begin
         c = (i / 2 < 4) ? (i / 2) * 8 : ((i / 2 == 4) ? 32'h20 : 32'h60);
         wr(`REG_PIN_CTRL, c);
         irq_req <= i[0];
         @(negedge clk);
         v = (c[5] ? c[6] : i[0]) ^ c[3];
         chk({30'h0, irq_lvl, irq_oe}, {30'h0, v, c[4] ? !v : 1'b1});
         @(posedge clk);
      end
      $display("pin test done");
      // loss mode with source switching
      wr(`REG_PIN_CTRL, 32'h04);
      act_b <= 1'b1;
      for (int i = 1; i >= 0; i--)
      begin
         sw <= i[0];
         repeat (8) @(posedge clk);
         @(negedge clk);
         chk({30'h0, sel_b, irq_lvl}, {30'h0, i[0], !i[0]});
         @(posedge clk);
      end
      act_c <= 1'b1;
      @(negedge clk);
      chk({31'h0, irq_lvl}, 32'h0);
      @(posedge clk);
      rd(`REG_STATUS, 32'he);
      // general-purpose pins, two outputs and two host-driven inputs
      brd_en <= 10'h280;
      brd_val <= 10'h080;
      wr(`REG_GP_PIN_CONTROL, 32'ha5);
      repeat (6) @(posedge clk);
      rd(`REG_GP_PIN_CONTROL, 32'ha5);
      rd(`REG_GP_PIN_STATE, 32'h2);
      chk({28'h0, gp_oe}, 32'h5);
      $display("loss and gp test done");
      finish_test;
   end
endmodule // tb_top
bind global_strap_pins strap_chk #(.GP_COUNT(GP_COUNT)) i_chk (.CLK(CLK), .RST(RST), .MASTER_RESET_N(MASTER_RESET_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .SOURCE_SWITCH_IN(SOURCE_SWITCH_IN), .REF_FAIL_PIN_OUT(REF_FAIL_PIN_OUT), .REF_FAIL_PIN_OE(REF_FAIL_PIN_OE),
   .LOCK_PIN_OUT(LOCK_PIN_OUT), .LOCK_PIN_OE(LOCK_PIN_OE), .GP_PIN_OUT(GP_PIN_OUT), .GP_PIN_OE(GP_PIN_OE),
   .IRQ_PIN_OUT(IRQ_PIN_OUT), .IRQ_PIN_OE(IRQ_PIN_OE), .SELECTED_REF_FAILURE(SELECTED_REF_FAILURE),
   .MAIN_DPLL_LOCKED(MAIN_DPLL_LOCKED), .ACTIVITY_B(ACTIVITY_B), .ACTIVITY_C(ACTIVITY_C),
   .IRQ_REQUEST(IRQ_REQUEST), .REF_SELECT_B(REF_SELECT_B), .DEVICE_RUN(DEVICE_RUN),
   .INPUT_B_RATE(INPUT_B_RATE), .CMOS_OUT_INPUT_RATE_FIELD(CMOS_OUT_INPUT_RATE_FIELD), .DIFF_OUT_INPUT_RATE_FIELD(DIFF_OUT_INPUT_RATE_FIELD),
   .RATE_FAMILY(RATE_FAMILY));
